//--- rtl/chs_supervisor.sv
// controller health supervisor: windows, parity, battery, lamps, alarms
`timescale 1ns/1ps
`include "chs_regs.svh"

module chs_supervisor #(
    parameter int unsigned WINDOW_CYC =
        `CHS_WINDOW_MS * `CHS_CLK_KHZ,
    parameter int unsigned FLASH_CYC =
        `CHS_FLASH_MS * `CHS_CLK_KHZ,
    parameter int unsigned ADDR_W = `CHS_ADDR_W
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic selftest_done_i,
    input wire logic io_scan_done_i,
    input wire logic sweep_start_i,
    input wire logic sweep_end_i,
    input wire logic start_req_i,
    input wire logic stop_req_i,
    input wire logic outputs_enable_i,
    input wire logic parity_err_i,
    input wire logic [ADDR_W-1:0] parity_addr_i,
    input wire logic mem_restored_i,
    input wire logic batt_low_i,
    input wire logic batt_fail_i,
    output logic check_led_o,
    output logic run_led_o,
    output logic enable_led_o,
    output logic parity_led_o,
    output logic batt_led_o,
    output logic alarm1_o,
    output logic alarm2_o,
    output logic io_reset_o,
    output logic force_stop_o,
    output logic flag_wr_o,
    output logic flag_parity_o,
    output logic flag_batt_o,
    output logic [ADDR_W-1:0] flag_addr_o
);
    localparam logic [`CHS_CNT_W-1:0] HALF_FLASH =
        `CHS_CNT_W'(FLASH_CYC / 2);

    chs_win_if st_win ();
    chs_win_if io_win ();
    chs_win_if sw_win ();

    chs_pkg::chs_mode_t mode_r;
    chs_pkg::chs_mode_t mode_nxt;
    chs_pkg::chs_batt_t batt_r;
    chs_pkg::chs_batt_t batt_nxt;

    logic in_sweep_r;
    logic in_sweep_nxt;
    logic parity_hold_r;
    logic parity_hold_nxt;
    logic [`CHS_CNT_W-1:0] flash_cnt_r;
    logic [`CHS_CNT_W-1:0] flash_cnt_nxt;
    logic flash_r;
    logic flash_nxt;

    logic check_led_nxt;
    logic run_led_nxt;
    logic enable_led_nxt;
    logic parity_led_nxt;
    logic batt_led_nxt;
    logic alarm1_nxt;
    logic alarm2_nxt;
    logic io_reset_nxt;
    logic force_stop_nxt;
    logic flag_wr_nxt;
    logic flag_parity_nxt;
    logic flag_batt_nxt;
    logic [ADDR_W-1:0] flag_addr_nxt;

    logic timeout_fault;
    logic hard_fault;
    logic restart_ok;

    // battery level classification, failed wins over low
    function automatic chs_pkg::chs_batt_t batt_class(
        input logic low,
        input logic fail
    );
        if (fail) begin
            return chs_pkg::CHS_BATT_FAILED;
        end else if (low) begin
            return chs_pkg::CHS_BATT_LOW;
        end
        return chs_pkg::CHS_BATT_NORMAL;
    endfunction

    // window timers: self-test, I/O scan, user program pass
    assign st_win.kick = selftest_done_i;
    assign st_win.run = 1'b1;
    assign io_win.kick = io_scan_done_i;
    assign io_win.run = 1'b1;
    assign sw_win.kick = sweep_start_i | sweep_end_i;
    assign sw_win.run = in_sweep_r;

    chs_window_timer #(
        .WINDOW_CYC(WINDOW_CYC)
    ) u_st_timer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .win(st_win.timer)
    );

    chs_window_timer #(
        .WINDOW_CYC(WINDOW_CYC)
    ) u_io_timer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .win(io_win.timer)
    );

    chs_window_timer #(
        .WINDOW_CYC(WINDOW_CYC)
    ) u_sw_timer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .win(sw_win.timer)
    );

    // fault summary
    assign timeout_fault = st_win.expired | sw_win.expired;
    assign hard_fault = timeout_fault | parity_err_i | parity_hold_r;
    assign restart_ok = (batt_r != chs_pkg::CHS_BATT_FAILED);

    // program pass tracking and parity persistence
    always_comb begin
        in_sweep_nxt = in_sweep_r;
        if (sweep_start_i) begin
            in_sweep_nxt = 1'b1;
        end else if (sweep_end_i) begin
            in_sweep_nxt = 1'b0;
        end
        parity_hold_nxt = parity_hold_r;
        if (parity_err_i) begin
            parity_hold_nxt = 1'b1; // set wins over restore
        end else if (mem_restored_i) begin
            parity_hold_nxt = 1'b0;
        end
    end

    // controller mode
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            chs_pkg::CHS_MODE_STOP: begin
                if (start_req_i && !hard_fault && restart_ok) begin
                    mode_nxt = outputs_enable_i ?
                        chs_pkg::CHS_MODE_RUN_EN :
                        chs_pkg::CHS_MODE_RUN_DIS;
                end
            end
            chs_pkg::CHS_MODE_RUN_DIS,
            chs_pkg::CHS_MODE_RUN_EN: begin
                // soft battery faults never stop the controller
                if (hard_fault || stop_req_i) begin
                    mode_nxt = chs_pkg::CHS_MODE_STOP;
                end else begin
                    mode_nxt = outputs_enable_i ?
                        chs_pkg::CHS_MODE_RUN_EN :
                        chs_pkg::CHS_MODE_RUN_DIS;
                end
            end
        endcase
    end

    // battery state and free-running flash divider
    always_comb begin
        batt_nxt = batt_class(batt_low_i, batt_fail_i);
        flash_cnt_nxt = flash_cnt_r + `CHS_CNT_ONE;
        flash_nxt = flash_r;
        if (flash_cnt_r + `CHS_CNT_ONE >= HALF_FLASH) begin
            flash_cnt_nxt = `CHS_CNT_RST;
            flash_nxt = !flash_r;
        end
    end

    // lamps, relays and I/O chain reset
    always_comb begin
        // check lamp only after a first self-test, so power-up is dark
        check_led_nxt = st_win.seen && !timeout_fault;
        run_led_nxt = (mode_nxt != chs_pkg::CHS_MODE_STOP) &&
            st_win.seen && io_win.seen &&
            !st_win.expired && !io_win.expired;
        enable_led_nxt = (mode_nxt == chs_pkg::CHS_MODE_RUN_EN);
        if (hard_fault) begin
            run_led_nxt = `CHS_LED_OFF;
            enable_led_nxt = `CHS_LED_OFF;
        end
        parity_led_nxt = !(parity_err_i || parity_hold_r);
        alarm1_nxt = hard_fault ?
            `CHS_RELAY_SWITCHED : `CHS_RELAY_IDLE;
        io_reset_nxt = timeout_fault;
        force_stop_nxt = hard_fault;
        unique case (batt_nxt)
            chs_pkg::CHS_BATT_NORMAL: begin
                batt_led_nxt = `CHS_LED_ON;
                alarm2_nxt = `CHS_RELAY_IDLE;
            end
            chs_pkg::CHS_BATT_LOW: begin
                batt_led_nxt = flash_r;
                alarm2_nxt = `CHS_RELAY_SWITCHED;
            end
            chs_pkg::CHS_BATT_FAILED: begin
                batt_led_nxt = `CHS_LED_OFF;
                alarm2_nxt = `CHS_RELAY_SWITCHED;
            end
        endcase
    end

    // scratch pad flag records
    always_comb begin
        flag_wr_nxt = 1'b0;
        flag_parity_nxt = flag_parity_o;
        flag_batt_nxt = flag_batt_o;
        flag_addr_nxt = flag_addr_o;
        if (parity_err_i) begin
            flag_wr_nxt = 1'b1;
            flag_parity_nxt = 1'b1;
            flag_addr_nxt = parity_addr_i;
        end else if (mem_restored_i && flag_parity_o) begin
            flag_wr_nxt = 1'b1;
            flag_parity_nxt = 1'b0;
        end
        if (batt_nxt != chs_pkg::CHS_BATT_NORMAL && !flag_batt_o) begin
            flag_wr_nxt = 1'b1;
            flag_batt_nxt = 1'b1;
        end else if (batt_nxt == chs_pkg::CHS_BATT_NORMAL && flag_batt_o) begin
            flag_wr_nxt = 1'b1;
            flag_batt_nxt = 1'b0;
        end
    end

    // internal state registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mode_r <= chs_pkg::CHS_MODE_STOP;
            batt_r <= chs_pkg::CHS_BATT_NORMAL;
            in_sweep_r <= 1'b0;
            parity_hold_r <= 1'b0;
            flash_cnt_r <= `CHS_CNT_RST;
            flash_r <= `CHS_LED_OFF;
        end else begin
            mode_r <= mode_nxt;
            batt_r <= batt_nxt;
            in_sweep_r <= in_sweep_nxt;
            parity_hold_r <= parity_hold_nxt;
            flash_cnt_r <= flash_cnt_nxt;
            flash_r <= flash_nxt;
        end
    end

    // output registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            check_led_o <= `CHS_LED_OFF;
            run_led_o <= `CHS_LED_OFF;
            enable_led_o <= `CHS_LED_OFF;
            parity_led_o <= `CHS_LED_ON;
            batt_led_o <= `CHS_LED_ON;
            alarm1_o <= `CHS_RELAY_IDLE;
            alarm2_o <= `CHS_RELAY_IDLE;
            io_reset_o <= 1'b0;
            force_stop_o <= 1'b0;
            flag_wr_o <= 1'b0;
            flag_parity_o <= 1'b0;
            flag_batt_o <= 1'b0;
            flag_addr_o <= ADDR_W'(`CHS_ADDR_RST);
        end else begin
            check_led_o <= check_led_nxt;
            run_led_o <= run_led_nxt;
            enable_led_o <= enable_led_nxt;
            parity_led_o <= parity_led_nxt;
            batt_led_o <= batt_led_nxt;
            alarm1_o <= alarm1_nxt;
            alarm2_o <= alarm2_nxt;
            io_reset_o <= io_reset_nxt;
            force_stop_o <= force_stop_nxt;
            flag_wr_o <= flag_wr_nxt;
            flag_parity_o <= flag_parity_nxt;
            flag_batt_o <= flag_batt_nxt;
            flag_addr_o <= flag_addr_nxt;
        end
    end
endmodule // chs_supervisor

//--- shared/chs_regs.svh
// timing figures, field widths and reset values of the health supervisor
`ifndef CHS_REGS_SVH
`define CHS_REGS_SVH

// system clock rate in kHz (50 MHz)
`define CHS_CLK_KHZ 50000
// supervision window, nominal, in ms
`define CHS_WINDOW_MS 300
// window tolerance in ms, either side of nominal
`define CHS_WINDOW_TOL_MS 50
// battery indicator flash period in ms
`define CHS_FLASH_MS 1000
// parity fault address width
`define CHS_ADDR_W 16
// counter width, wide enough for every count in this block
`define CHS_CNT_W 32

// reset values of indicators and relays
`define CHS_LED_OFF 1'h0
`define CHS_LED_ON 1'h1
`define CHS_RELAY_IDLE 1'h0
`define CHS_RELAY_SWITCHED 1'h1
`define CHS_ADDR_RST 16'h0000
`define CHS_CNT_RST 32'h0000_0000
`define CHS_CNT_ONE 32'h0000_0001

`endif

//--- shared/chs_pkg.sv
// types shared by the health supervisor modules
package chs_pkg;

    // controller mode as kept by the supervisor
    typedef enum logic [1:0] {
        CHS_MODE_STOP,
        CHS_MODE_RUN_DIS,
        CHS_MODE_RUN_EN
    } chs_mode_t;

    // memory backup battery condition
    typedef enum logic [1:0] {
        CHS_BATT_NORMAL,
        CHS_BATT_LOW,
        CHS_BATT_FAILED
    } chs_batt_t;

endpackage

//--- shared/chs_win_if.sv
// link between the supervisor and one window timer
`timescale 1ns/1ps

interface chs_win_if;
    logic kick;    // event seen, restart the window
    logic run;     // window counting enabled
    logic expired; // window ran out without a kick
    logic seen;    // at least one kick since reset

    modport timer (
        input kick,
        input run,
        output expired,
        output seen
    );
    modport user (
        output kick,
        output run,
        input expired,
        input seen
    );
endinterface

//--- rtl/chs_window_timer.sv
// retriggerable window timer with sticky expiry
`timescale 1ns/1ps
`include "chs_regs.svh"

module chs_window_timer #(
    parameter int unsigned WINDOW_CYC = `CHS_WINDOW_MS * `CHS_CLK_KHZ
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    chs_win_if.timer win
);
    localparam logic [`CHS_CNT_W-1:0] LAST =
        `CHS_CNT_W'(WINDOW_CYC - 1);

    logic [`CHS_CNT_W-1:0] cnt_r;
    logic [`CHS_CNT_W-1:0] cnt_nxt;
    logic expired_r;
    logic expired_nxt;
    logic seen_r;
    logic seen_nxt;

    // kick restarts, idle clears the count, otherwise count up to the window end and hold
    always_comb begin
        cnt_nxt = cnt_r;
        expired_nxt = expired_r;
        seen_nxt = seen_r;
        if (win.kick) begin
            cnt_nxt = `CHS_CNT_RST;
            expired_nxt = 1'b0;
            seen_nxt = 1'b1;
        end else if (win.run && !expired_r) begin
            if (cnt_r >= LAST) begin
                expired_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + `CHS_CNT_ONE;
            end
        end else if (!win.run) begin
            cnt_nxt = `CHS_CNT_RST; // idle window restarts fresh
        end
    end

    // state registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_r <= `CHS_CNT_RST;
            expired_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            expired_r <= expired_nxt;
            seen_r <= seen_nxt;
        end
    end

    assign win.expired = expired_r;
    assign win.seen = seen_r;
endmodule // chs_window_timer

//--- verif/chs_sup_sva.sv
// port assertions of the health supervisor
`timescale 1ns/1ps

module chs_sup_sva #(
    parameter int unsigned FLASH_CYC = 8,
    parameter int unsigned ADDR_W = 16
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic parity_err_i,
    input wire logic [ADDR_W-1:0] parity_addr_i,
    input wire logic batt_low_i,
    input wire logic batt_fail_i,
    input wire logic check_led_o,
    input wire logic run_led_o,
    input wire logic enable_led_o,
    input wire logic parity_led_o,
    input wire logic batt_led_o,
    input wire logic alarm1_o,
    input wire logic alarm2_o,
    input wire logic io_reset_o,
    input wire logic force_stop_o,
    input wire logic flag_wr_o,
    input wire logic flag_parity_o,
    input wire logic flag_batt_o,
    input wire logic [ADDR_W-1:0] flag_addr_o
);
    logic prev_r, prev_nxt;
    logic [31:0] stbl_r, stbl_nxt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // cycles the battery lamp stayed unchanged
    always_comb begin
        prev_nxt = batt_led_o;
        stbl_nxt = (batt_led_o != prev_r) ? 32'h0 : stbl_r + 32'h1;
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            prev_r <= 1'h1;
            stbl_r <= 32'h0;
        end else begin
            prev_r <= prev_nxt;
            stbl_r <= stbl_nxt;
        end
    end

    property p_timeout;
        io_reset_o |-> !check_led_o && !run_led_o && !enable_led_o
            && alarm1_o;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout lamps");
    property p_hard;
        alarm1_o |-> force_stop_o && !run_led_o && !enable_led_o;
    endproperty
    a_hard: assert property (p_hard) else $error("hard fault runs");
    property p_run_chk;
        run_led_o |-> check_led_o;
    endproperty
    a_run_chk: assert property (p_run_chk) else $error("run no check");
    property p_parity;
        parity_err_i |=> !parity_led_o && alarm1_o && flag_parity_o
            && flag_addr_o == $past(parity_addr_i);
    endproperty
    a_parity: assert property (p_parity) else $error("parity");
    property p_par_flag;
        $rose(flag_parity_o) |-> flag_wr_o && !parity_led_o;
    endproperty
    a_par_flag: assert property (p_par_flag) else $error("par flag");
    property p_batt_fail;
        batt_fail_i |=> !batt_led_o && alarm2_o;
    endproperty
    a_batt_fail: assert property (p_batt_fail) else $error("fail");
    property p_batt_norm;
        !batt_low_i && !batt_fail_i |=> batt_led_o && !alarm2_o;
    endproperty
    a_batt_norm: assert property (p_batt_norm) else $error("norm");
    property p_flash;
        (batt_low_i && !batt_fail_i) [*8] |-> stbl_r < FLASH_CYC;
    endproperty
    a_flash: assert property (p_flash) else $error("no flash");
    property p_soft;
        $rose(flag_batt_o) |-> flag_wr_o && alarm2_o && !force_stop_o;
    endproperty
    a_soft: assert property (p_soft) else $error("soft fault");
endmodule // chs_sup_sva

bind chs_supervisor chs_sup_sva #(
    .FLASH_CYC(FLASH_CYC),
    .ADDR_W(ADDR_W)
) i_chs_sup_sva (
    .clk_i, .resetn_i, .parity_err_i, .parity_addr_i, .batt_low_i,
    .batt_fail_i, .check_led_o, .run_led_o, .enable_led_o, .parity_led_o,
    .batt_led_o, .alarm1_o, .alarm2_o, .io_reset_o, .force_stop_o,
    .flag_wr_o, .flag_parity_o, .flag_batt_o, .flag_addr_o
);

//--- verif/chs_seq_model.sv
// execution sequencer model: passes, self-tests, I/O scans
`timescale 1ns/1ps

module chs_seq_model #(
    parameter int unsigned PERIOD = 10
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic st_en_i,
    input wire logic io_en_i,
    input wire logic long_i,
    output logic selftest_o,
    output logic io_scan_o,
    output logic start_o,
    output logic end_o
);
    logic [7:0] cnt_r, cnt_nxt;
    logic pass_r, pass_nxt;

    // events at fixed steps of each period; long holds the pass open
    always_comb begin
        start_o = (cnt_r == 8'h00) && !pass_r;
        selftest_o = st_en_i && (cnt_r == 8'h02);
        io_scan_o = io_en_i && (cnt_r == 8'h04);
        end_o = pass_r && !long_i && (cnt_r == 8'h06);
        cnt_nxt = (cnt_r == 8'(PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
        pass_nxt = start_o || (pass_r && !end_o);
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_r <= 8'h01;
            pass_r <= 1'h0;
        end else begin
            cnt_r <= cnt_nxt;
            pass_r <= pass_nxt;
        end
    end
endmodule // chs_seq_model

//--- verif/chs_supervisor_tb_top.sv
// self-checking bench of the health supervisor
`timescale 1ns/1ps

`define CHK(nm, e, s) n_compared++; if ((s) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, s); end

module chs_supervisor_tb_top;
    localparam int unsigned WIN = 50;
    localparam int unsigned FLASH = 8;
    logic clk_i, resetn, st, io, sw_s, sw_e, start_req, stop_req, out_en;
    logic par_err, restored, b_low, b_fail, st_en, io_en, long_sw;
    logic [15:0] par_addr, f_addr;
    logic check_led, run_led, en_led, par_led, batt_led, al1, al2;
    logic io_rst, f_stop, f_par, f_batt;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    chs_supervisor #(.WINDOW_CYC(WIN), .FLASH_CYC(FLASH)) i_chs_supervisor (
        .clk_i(clk_i), .resetn_i(resetn), .selftest_done_i(st),
        .io_scan_done_i(io), .sweep_start_i(sw_s), .sweep_end_i(sw_e),
        .start_req_i(start_req), .stop_req_i(stop_req),
        .outputs_enable_i(out_en), .parity_err_i(par_err),
        .parity_addr_i(par_addr), .mem_restored_i(restored),
        .batt_low_i(b_low), .batt_fail_i(b_fail), .check_led_o(check_led),
        .run_led_o(run_led), .enable_led_o(en_led), .parity_led_o(par_led),
        .batt_led_o(batt_led), .alarm1_o(al1), .alarm2_o(al2),
        .io_reset_o(io_rst), .force_stop_o(f_stop), .flag_wr_o(),
        .flag_parity_o(f_par), .flag_batt_o(f_batt), .flag_addr_o(f_addr));
    chs_seq_model i_chs_seq_model (
        .clk_i(clk_i), .resetn_i(resetn), .st_en_i(st_en), .io_en_i(io_en),
        .long_i(long_sw), .selftest_o(st), .io_scan_o(io), .start_o(sw_s),
        .end_o(sw_e));

    // clock and hang limit
    initial begin
        clk_i = 1'h0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            $display("unexpected cycles exp %0d got %0d", 2999, cycles);
            num_errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // one start or stop request pulse
    task automatic req(input logic go);
        start_req = go;
        stop_req = !go;
        cyc(1);
        start_req = 1'h0;
        stop_req = 1'h0;
        cyc(2);
    endtask
    task automatic t_run();
        cyc(12);
        `CHK("check_led", 1'h1, check_led)
        `CHK("run_led", 1'h0, run_led)
        req(1'h1);
        `CHK("run_led", 1'h1, run_led)
        `CHK("enable_led", 1'h1, en_led)
        req(1'h0);
        `CHK("run_led", 1'h0, run_led)
        `CHK("enable_led", 1'h0, en_led)
        req(1'h1);
    endtask
    // lose self-test (0), end of pass (1) or I/O scan (2)
    task automatic t_lost(input int k);
        st_en = (k != 0);
        long_sw = (k == 1);
        io_en = (k != 2);
        cyc(WIN + 20);
        `CHK("run_led", 1'h0, run_led)
        if (k == 2) begin
            `CHK("check_led", 1'h1, check_led)
        end else begin
            `CHK("check_led", 1'h0, check_led)
            `CHK("alarm1", 1'h1, al1)
            `CHK("io_reset", 1'h1, io_rst)
            `CHK("force_stop", 1'h1, f_stop)
        end
        st_en = 1'h1;
        long_sw = 1'h0;
        io_en = 1'h1;
        cyc(25);
        `CHK("io_reset", 1'h0, io_rst)
        req(1'h1);
        `CHK("run_led", 1'h1, run_led)
    endtask
    task automatic t_parity();
        par_addr = 16'hA5C3;
        par_err = 1'h1;
        cyc(1);
        par_err = 1'h0;
        cyc(1);
        `CHK("parity_led", 1'h0, par_led)
        `CHK("alarm1", 1'h1, al1)
        `CHK("enable_led", 1'h0, en_led)
        `CHK("flag_parity", 1'h1, f_par)
        `CHK("flag_addr", 16'hA5C3, f_addr)
        req(1'h1);
        `CHK("run_led", 1'h0, run_led)
        restored = 1'h1;
        cyc(1);
        restored = 1'h0;
        cyc(2);
        `CHK("parity_led", 1'h1, par_led)
        req(1'h1);
        `CHK("run_led", 1'h1, run_led)
    endtask
    task automatic t_batt();
        logic s0, s1;
        s0 = 1'h0;
        s1 = 1'h0;
        b_low = 1'h1;
        cyc(2);
        repeat (FLASH) begin
            s0 |= !batt_led;
            s1 |= batt_led;
            cyc(1);
        end
        `CHK("batt_flash", 1'h1, s0 & s1)
        `CHK("alarm2", 1'h1, al2)
        `CHK("flag_batt", 1'h1, f_batt)
        req(1'h0);
        req(1'h1);
        `CHK("run_led", 1'h1, run_led)
        b_fail = 1'h1;
        cyc(3);
        `CHK("batt_led", 1'h0, batt_led)
        `CHK("run_led", 1'h1, run_led)
        req(1'h0);
        req(1'h1);
        `CHK("run_led", 1'h0, run_led)
        b_low = 1'h0;
        b_fail = 1'h0;
        cyc(3);
        `CHK("batt_led", 1'h1, batt_led)
        `CHK("alarm2", 1'h0, al2)
    endtask

    // reset, then the scenarios in turn
    initial begin
        {resetn, start_req, stop_req, par_err, restored, b_low} = 6'h00;
        {b_fail, long_sw, par_addr} = 18'h00000;
        {st_en, io_en, out_en} = 3'h7;
        cyc(4);
        resetn = 1'h1;
        cyc(1);
        `CHK("parity_led", 1'h1, par_led)
        `CHK("alarm1", 1'h0, al1)
        `CHK("check_led", 1'h0, check_led)
        `CHK("run_led", 1'h0, run_led)
        t_run();
        t_lost(0);
        t_lost(1);
        t_lost(2);
        t_parity();
        t_batt();
        test_done();
    end
endmodule // chs_supervisor_tb_top
